/* File: design/stp_pkg.sv */
// Constants, register map and selector encodings for the shared timer
// prescaler and clock-select block.
// Assumes one system clock; software reaches the registers over Wishbone.
//
// Overview of operation
// - Select value 1 ticks every system clock cycle.
// - Four prescaler taps divide the system clock by 8, 64, 256, 1024.
// - One free-running prescaler serves all three timers; selects are separate.
// - First prescaled tick comes 1 to N cycles after enabling.
// - A prescaler reset restarts the period for every timer on a prescaler tap.
// - Pin sampled by high-transparent latch, then rising-edge registers.
// - One tick per rising edge at select 7, falling edge at 6.
// - Pin edge to tick latency is 2.5 to 3.5 clock cycles.
// - External edges become ticks directly, never prescaled.
// - Sync hold mode keeps written prescaler reset bits asserted.
// - Clearing sync hold mode clears both prescaler reset bits together.
// - Shared prescaler reset bit resets prescaler, self-clears unless held.
// - No source selected gives no ticks.
// - Select value 0 means stopped; count stays accessible.

`default_nettype none

package stp_pkg;

   localparam logic [3:0] ADDR_GENERAL_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h4;
   localparam logic [3:0] ADDR_PRESCALER = 4'h8;

   localparam int BIT_SHARED_RESET = 0;
   localparam int BIT_ASYNC_RESET = 1;
   localparam int BIT_SYNC_HOLD = 7;
   localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h00;
   localparam logic [7:0] GENERAL_CONTROL_MASK = 8'h83;

   // Clock select field: 3 bits per timer, timer n at bits 3n+2:3n.
   localparam int SELECT_WIDTH = 3;
   localparam int TIMER_COUNT = 3;
   localparam logic [8:0] CLOCK_SELECT_RESET = 9'h000;

   localparam logic [2:0] SEL_STOPPED = 3'h0;
   localparam logic [2:0] SEL_DIRECT = 3'h1;
   localparam logic [2:0] SEL_DIV8 = 3'h2;
   localparam logic [2:0] SEL_DIV64 = 3'h3;
   localparam logic [2:0] SEL_DIV256 = 3'h4;
   localparam logic [2:0] SEL_DIV1024 = 3'h5;
   localparam logic [2:0] SEL_EXT_FALL = 3'h6;
   localparam logic [2:0] SEL_EXT_RISE = 3'h7;

   localparam int PRESCALER_WIDTH = 10;
   localparam logic [9:0] PRESCALER_RESET = 10'h000;
   localparam logic [9:0] LAST_DIV8 = 10'h007;
   localparam logic [9:0] LAST_DIV64 = 10'h03f;
   localparam logic [9:0] LAST_DIV256 = 10'h0ff;
   localparam logic [9:0] LAST_DIV1024 = 10'h3ff;

endpackage : stp_pkg

`default_nettype wire

/* File: design/stp_prescaler.sv */
// Free-running ten-bit prescaler shared by all three timers, with taps.
// Assumes a synchronous reset request from the control register logic.

`default_nettype none

module stp_prescaler (
   input wire logic clock, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic clear, // Prescaler reset request, level.
   output logic [3:0] taps, // Tap pulses: div 8, 64, 256, 1024.
   output logic [9:0] count // Current prescaler phase.
);

   typedef struct packed {
      logic [9:0] count;
   } stp_prescaler_state_type;

   stp_prescaler_state_type state;
   stp_prescaler_state_type next_state;

   always_comb begin
      next_state = state;
      // Held at zero while cleared, so every prescaled timer restarts its period.
      if (clear) begin
         next_state.count = stp_pkg::PRESCALER_RESET;
      end else begin
         next_state.count = state.count + 10'h001;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state.count <= stp_pkg::PRESCALER_RESET;
      end else begin
         state <= next_state;
      end
   end

   // A tap fires on the last cycle of its period; none fire while held.
   assign taps[0] = !clear && (state.count[2:0] == stp_pkg::LAST_DIV8[2:0]);
   assign taps[1] = !clear && (state.count[5:0] == stp_pkg::LAST_DIV64[5:0]);
   assign taps[2] = !clear && (state.count[7:0] == stp_pkg::LAST_DIV256[7:0]);
   assign taps[3] = !clear && (state.count == stp_pkg::LAST_DIV1024);
   assign count = state.count;

   a_tap_period: assert property (@(posedge clock) disable iff (!reset_n)
      taps[0] |=> !taps[0] [*7])
      else $error("divide by 8 tap fired early");

endmodule : stp_prescaler

`default_nettype wire

/* File: design/stp_pin_sync.sv */
// Samples one external count pin and reports its rising and falling edges.
// Assumes the pin is asynchronous to the system clock.

`default_nettype none

module stp_pin_sync (
   input wire logic clock, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic external_count_pin, // Raw pin level.
   output logic rise, // Rising edge seen, one-cycle pulse.
   output logic fall // Falling edge seen, one-cycle pulse.
);

   typedef struct packed {
      logic meta;
      logic synced;
      logic previous;
   } stp_pin_state_type;

   stp_pin_state_type state;
   stp_pin_state_type next_state;
   logic latched;

   // The latch, open while the clock is high, gives the half cycle of the
   // 2.5 to 3.5 cycle latency and halves the metastability window.
   always_latch begin
      if (clock) begin
         latched = external_count_pin;
      end
   end

   always_comb begin
      next_state = state;
      next_state.meta = latched;
      next_state.synced = state.meta;
      next_state.previous = state.synced;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rise = state.synced && !state.previous;
   assign fall = !state.synced && state.previous;

   a_single_edge: assert property (@(posedge clock) disable iff (!reset_n)
      rise |=> !rise)
      else $error("two rising edge pulses in a row");

endmodule : stp_pin_sync

`default_nettype wire

/* File: design/stp_timer_clock_select.sv */
// Top of the shared prescaler and clock selection for three timers.
// Assumes a classic Wishbone master on the system clock and raw external
// count pins from outside the chip.

`default_nettype none

module stp_timer_clock_select (
   input wire logic clock, // System clock, 40 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic wb_cyc_i, // Wishbone cycle.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [3:0] wb_adr_i, // Wishbone byte address.
   input wire logic [3:0] wb_sel_i, // Wishbone byte lanes.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   output logic wb_ack_o, // Wishbone acknowledge.
   input wire logic [2:0] external_count_pin, // Raw count pins.
   output logic [2:0] timer_count_tick, // Count tick per timer.
   output logic async_prescaler_reset // Reset to the other prescaler.
);

   typedef struct packed {
      logic sync_hold_mode;
      logic async_prescaler_reset;
      logic shared_prescaler_reset;
      logic [8:0] clock_select_field;
      logic ack;
      logic [31:0] read_data;
      logic [2:0] tick;
   } stp_top_state_type;

   stp_top_state_type state;
   stp_top_state_type next_state;
   logic [3:0] taps;
   logic [9:0] prescaler_count;
   logic [2:0] ext_rise;
   logic [2:0] ext_fall;
   logic request;

   // The shared reset bit drives the prescaler directly; in hold mode it
   // stays set, so every prescaled timer stays frozen together.
   stp_prescaler prescaler (
      .clock(clock),
      .reset_n(reset_n),
      .clear(state.shared_prescaler_reset),
      .taps(taps),
      .count(prescaler_count)
   );

   genvar gi;
   generate
      for (gi = 0; gi < stp_pkg::TIMER_COUNT; gi++) begin : g_pin
         stp_pin_sync pin_sync (
            .clock(clock),
            .reset_n(reset_n),
            .external_count_pin(external_count_pin[gi]),
            .rise(ext_rise[gi]),
            .fall(ext_fall[gi])
         );
      end
   endgenerate

   // Chooses one timer's tick source from its 3-bit select value.
   function automatic logic pick_tick(input logic [2:0] sel,
                                      input logic [3:0] tap,
                                      input logic up,
                                      input logic down);
      logic result;
      result = 1'b0;
      case (sel)
         stp_pkg::SEL_STOPPED: result = 1'b0;
         stp_pkg::SEL_DIRECT: result = 1'b1;
         stp_pkg::SEL_DIV8: result = tap[0];
         stp_pkg::SEL_DIV64: result = tap[1];
         stp_pkg::SEL_DIV256: result = tap[2];
         stp_pkg::SEL_DIV1024: result = tap[3];
         stp_pkg::SEL_EXT_FALL: result = down;
         stp_pkg::SEL_EXT_RISE: result = up;
         default: result = 1'b0;
      endcase
      return result;
   endfunction : pick_tick

   function automatic logic [31:0] general_word(input stp_top_state_type s);
      return {24'h000000, s.sync_hold_mode, 5'h00,
              s.async_prescaler_reset, s.shared_prescaler_reset};
   endfunction : general_word

   assign request = wb_cyc_i && wb_stb_i && !state.ack;

   always_comb begin
      next_state = state;
      next_state.ack = request;
      next_state.read_data = 32'h00000000;

      // Self-clearing: a set reset bit lasts one cycle unless held.
      if (!state.sync_hold_mode) begin
         next_state.shared_prescaler_reset = 1'b0;
         next_state.async_prescaler_reset = 1'b0;
      end

      for (int t = 0; t < stp_pkg::TIMER_COUNT; t++) begin
         next_state.tick[t] = pick_tick(
            state.clock_select_field[t*3 +: 3], taps,
            ext_rise[t], ext_fall[t]);
      end

      if (request && wb_we_i && wb_sel_i[0]) begin
         case (wb_adr_i)
            stp_pkg::ADDR_GENERAL_CONTROL: begin
               next_state.sync_hold_mode =
                  wb_dat_i[stp_pkg::BIT_SYNC_HOLD];
               if (wb_dat_i[stp_pkg::BIT_SYNC_HOLD]) begin
                  // Held bits keep whatever software writes.
                  next_state.shared_prescaler_reset =
                     wb_dat_i[stp_pkg::BIT_SHARED_RESET];
                  next_state.async_prescaler_reset =
                     wb_dat_i[stp_pkg::BIT_ASYNC_RESET];
               end else if (state.sync_hold_mode) begin
                  // Leaving hold releases both prescalers on one edge.
                  next_state.shared_prescaler_reset = 1'b0;
                  next_state.async_prescaler_reset = 1'b0;
               end else begin
                  next_state.shared_prescaler_reset =
                     wb_dat_i[stp_pkg::BIT_SHARED_RESET];
                  next_state.async_prescaler_reset =
                     wb_dat_i[stp_pkg::BIT_ASYNC_RESET];
               end
            end
            stp_pkg::ADDR_CLOCK_SELECT: begin
               next_state.clock_select_field[7:0] = wb_dat_i[7:0];
            end
            default: begin
            end
         endcase
      end
      if (request && wb_we_i && wb_sel_i[1] &&
          wb_adr_i == stp_pkg::ADDR_CLOCK_SELECT) begin
         next_state.clock_select_field[8] = wb_dat_i[8];
      end

      if (request && !wb_we_i) begin
         case (wb_adr_i)
            stp_pkg::ADDR_GENERAL_CONTROL:
               next_state.read_data = general_word(state);
            stp_pkg::ADDR_CLOCK_SELECT:
               next_state.read_data = {23'h000000, state.clock_select_field};
            stp_pkg::ADDR_PRESCALER:
               next_state.read_data = {22'h000000, prescaler_count};
            default:
               next_state.read_data = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state.sync_hold_mode <= 1'b0;
         state.async_prescaler_reset <= 1'b0;
         state.shared_prescaler_reset <= 1'b0;
         state.clock_select_field <= stp_pkg::CLOCK_SELECT_RESET;
         state.ack <= 1'b0;
         state.read_data <= 32'h00000000;
         state.tick <= 3'h0;
      end else begin
         state <= next_state;
      end
   end

   assign wb_ack_o = state.ack;
   assign wb_dat_o = state.read_data;
   assign timer_count_tick = state.tick;
   assign async_prescaler_reset = state.async_prescaler_reset;

   a_stopped_silent: assert property (@(posedge clock) disable iff (!reset_n)
      state.clock_select_field[2:0] == stp_pkg::SEL_STOPPED ##1
      state.clock_select_field[2:0] == stp_pkg::SEL_STOPPED
      |-> !timer_count_tick[0])
      else $error("stopped timer ticked");

   a_direct_tick: assert property (@(posedge clock) disable iff (!reset_n)
      state.clock_select_field[2:0] == stp_pkg::SEL_DIRECT
      |=> timer_count_tick[0])
      else $error("direct select did not tick");

   a_reset_self_clear: assert property (@(posedge clock)
      disable iff (!reset_n)
      state.shared_prescaler_reset && !state.sync_hold_mode
      && !request |=> !state.shared_prescaler_reset)
      else $error("shared reset bit did not clear");

   a_hold_keeps: assert property (@(posedge clock) disable iff (!reset_n)
      state.sync_hold_mode && state.shared_prescaler_reset && !request
      |=> state.shared_prescaler_reset)
      else $error("held reset bit dropped");

   a_release_both: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(state.sync_hold_mode) |-> !state.shared_prescaler_reset
      && !state.async_prescaler_reset)
      else $error("reset bits survived hold release");

   sequence ext_rise_seen;
      ext_rise[0] && state.clock_select_field[2:0] == stp_pkg::SEL_EXT_RISE;
   endsequence

   a_ext_tick: assert property (@(posedge clock) disable iff (!reset_n)
      ext_rise_seen |=> timer_count_tick[0])
      else $error("external edge lost");

   a_div8_tick: assert property (@(posedge clock) disable iff (!reset_n)
      state.clock_select_field[2:0] == stp_pkg::SEL_DIV8 && taps[0]
      |=> timer_count_tick[0])
      else $error("divide by 8 tap not routed");

   a_held_frozen: assert property (@(posedge clock) disable iff (!reset_n)
      state.shared_prescaler_reset |=> prescaler_count == 10'h000)
      else $error("prescaler ran during reset");

endmodule : stp_timer_clock_select

`default_nettype wire

/* File: verif/stp_pin_source.sv */
// Behavioural source of count edges on the three external count pins.
// Assumes the bench pulses start for one cycle while the pins are idle.

`default_nettype none

module stp_pin_source (
   input wire logic clock, // System clock.
   input wire logic start, // Begin a burst of edges.
   input wire logic [7:0] edges, // Edges in the burst.
   input wire logic [7:0] half, // Cycles per half period, 2 or more.
   output logic [2:0] pin // Count pins, all three driven alike.
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] left = 8'h00;
   logic [7:0] n = 8'h00;

   initial pin = 3'h0;

   // Half periods of at least two cycles keep the source below the sampling
   // limit, and the pins rest between bursts so selects change safely.
   always @(posedge clock) begin
      if (start) begin
         left <= edges;
         n <= 8'h00;
      end else if (left != 8'h00) begin
         if (n == half - 8'h01) begin
            pin <= ~pin;
            left <= left - 8'h01;
            n <= 8'h00;
         end else begin
            n <= n + 8'h01;
         end
      end
   end

endmodule : stp_pin_source

`default_nettype wire

/* File: verif/stp_timer_clock_select_tb.sv */
// Self-checking bench for the shared prescaler and clock selection.
// Assumes the design answers classic Wishbone cycles with a one-cycle ack.

`default_nettype none

module stp_timer_clock_select_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [2:0] pin;
   logic [2:0] tick;
   logic async_prescaler_reset;
   logic start = 1'b0;
   logic ext = 1'b0;
   logic [31:0] rd;
   int errors = 0;
   int checks = 0;
   int cnt[3];
   int differ;
   int divs[5] = '{1, 8, 64, 256, 1024};
   int s;

   always #12.5 clock = ~clock;

   stp_pin_source u_stp_pin_source (.clock(clock), .start(start),
      .edges(8'h10), .half(8'h04), .pin(pin));

   stp_timer_clock_select u_stp_timer_clock_select (.clock(clock),
      .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .external_count_pin(pin), .timer_count_tick(tick),
      .async_prescaler_reset(async_prescaler_reset));

   task summarize;
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task check(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int i;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clock);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         errors++;
         $display("[ERR] wb ack expected 1 seen %b", wb_ack_o);
         summarize();
      end
   endtask : wb

   task rd_chk(input string what, input logic [3:0] adr, input logic [31:0] e);
      wb(1'b0, adr, 32'h0);
      check(what, e, rd);
   endtask : rd_chk

   // Ticks are sampled at the edge, so each pulse is seen exactly once.
   task count(input int cycles);
      int i, t, rise_at, lat;
      logic pin_q;
      cnt = '{0, 0, 0};
      differ = 0;
      rise_at = 0;
      pin_q = pin[0];
      for (i = 0; i < cycles; i++) begin
         @(posedge clock);
         for (t = 0; t < 3; t++) if (tick[t] === 1'b1) cnt[t]++;
         if (tick[0] !== tick[1]) differ++;
         if (pin[0] === 1'b1 && pin_q === 1'b0) rise_at = i;
         pin_q = pin[0];
         if (ext && tick[0] === 1'b1) begin
            lat = i - rise_at;
            checks++;
            if (lat < 2 || lat > 4) begin
               errors++;
               $display("[ERR] pin latency expected 2..4 seen %0d", lat);
            end
         end
      end
   endtask : count

   initial begin
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      rd_chk("control reset", stp_pkg::ADDR_GENERAL_CONTROL, 32'h0);
      rd_chk("select reset", stp_pkg::ADDR_CLOCK_SELECT, 32'h0);
      wb(1'b1, 4'hc, 32'hff);
      rd_chk("unmapped", 4'hc, 32'h0);
      for (s = 1; s <= 5; s++) begin
         wb(1'b1, stp_pkg::ADDR_CLOCK_SELECT, 32'(s));
         repeat (4) @(posedge clock);
         count(4 * divs[s-1]);
         check("ticks timer0", 32'h4, cnt[0]);
         check("ticks timer1", 32'h0, cnt[1]);
      end
      wb(1'b1, stp_pkg::ADDR_GENERAL_CONTROL, 32'h01);
      rd_chk("control", stp_pkg::ADDR_GENERAL_CONTROL, 32'h0);
      wb(1'b0, stp_pkg::ADDR_PRESCALER, 32'h0);
      check("prescaler restart", 32'h1, {31'h0, rd < 32'h10});
      wb(1'b1, stp_pkg::ADDR_CLOCK_SELECT, 32'h52);
      wb(1'b1, stp_pkg::ADDR_GENERAL_CONTROL, 32'h83);
      rd_chk("control", stp_pkg::ADDR_GENERAL_CONTROL, 32'h83);
      check("async reset", 32'h1, {31'h0, async_prescaler_reset});
      count(40);
      check("held timer0", 32'h0, cnt[0]);
      check("held timer1", 32'h0, cnt[1]);
      check("direct timer2", 32'd40, cnt[2]);
      wb(1'b1, stp_pkg::ADDR_GENERAL_CONTROL, 32'h0);
      rd_chk("control", stp_pkg::ADDR_GENERAL_CONTROL, 32'h0);
      check("async reset", 32'h0, {31'h0, async_prescaler_reset});
      count(80);
      check("released timer0", 32'd10, cnt[0]);
      check("timers in step", 32'h0, differ);
      wb(1'b1, stp_pkg::ADDR_CLOCK_SELECT, 32'h37);
      ext = 1'b1;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      count(100);
      check("rising ticks", 32'h8, cnt[0]);
      check("falling ticks", 32'h8, cnt[1]);
      check("stopped timer2", 32'h0, cnt[2]);
      summarize();
   end

endmodule : stp_timer_clock_select_tb

`default_nettype wire
